// *** rtl/thermal_event_control.sv ***
// Purpose: Package thermal event logic: activation, hot pin, trip, modulation
// Assumes: Sensor margins come from logic on mclk_i; hot pin is active low
// Notes:   Overview of operation follows
// Overview of operation
// - Environmental read returns hottest-sensor average over 256 ms.
// - Core status read returns the selected sensor's instantaneous value; package status read returns the hottest.
// - Readings are degrees below junction limit, offset not applied.
// - Readout saturates at the junction limit, never above.
// - Reading at activation point activates thermal control and throttles.
// - Two programmable thresholds can raise interrupts on crossing.
// - Hot pin is asserted while thermal control is active.
// - Hot pin assertion ignores adaptive monitor enabling.
// - After reset the hot pin is input only.
// - External hot assertion forces lowest performance state at once.
// - External hot assertion does not engage clock modulation.
// - Lowest state holds until the external agent releases the pin.
// - Optional interrupt on both edges of external hot.
// - While driving the pin, external assertion is not seen.
// - External response under 100 us; internal steps are slow.
// - Idle drops pin drive; wake reasserts if still hot.
// - Environmental averaging keeps running in every idle state.
// - Damaging temperature shuts down and asserts trip output.
// - Sustained activation sets critical status while it lasts and latches sticky bit.
// - Active thermal modulation duty overrides software duty.
// - I/O-emulated request duty beats register-based request duty.
// - Thermal modulation is 25 percent on with 32 us period.
// - Software duty in 12.5 or 6.25 percent steps, step discoverable.
module thermal_event_control #(
  parameter int STEP_CYCLES = therm_pkg::THROT_STEP_CYCLES,
  parameter int CRIT_CYCLES = therm_pkg::CRIT_CYCLES,
  parameter int AVG_CYCLES  = therm_pkg::AVG_SAMPLE_CYCLES,
  parameter logic [7:0] JLIM = therm_pkg::JLIM_DEFAULT
) (
  input  wire logic                                mclk_i,
  input  wire logic                                reset_i,
  input  wire logic [therm_pkg::SENS_N-1:0][7:0]   sensor_raw_i,
  input  wire logic [1:0]                          sensor_sel_i,
  input  wire logic [6:0]                          thr1_i,
  input  wire logic [6:0]                          thr2_i,
  input  wire logic                                thr_int_en_i,
  input  wire logic                                hot_int_en_i,
  input  wire logic                                crit_int_en_i,
  input  wire logic                                bidir_en_i,
  input  wire logic                                idle_i,
  input  wire logic                                odm_en_i,
  input  wire logic [3:0]                          odm_duty_i,
  input  wire logic                                io_odm_en_i,
  input  wire logic [3:0]                          io_odm_duty_i,
  input  wire logic                                hot_pin_i,
  output logic                                     hot_pin_o,
  output logic                                     hot_pin_oe_o,
  input  wire logic                                msr_rd_i,
  input  wire logic                                msr_wr_i,
  input  wire logic [15:0]                         msr_addr_i,
  input  wire logic [63:0]                         msr_wdata_i,
  output logic [63:0]                              msr_rdata_o,
  output logic                                     msr_rvalid_o,
  output logic [6:0]                               env_temp_o,
  output logic                                     circuit_active_o,
  output logic [2:0]                               throttle_level_o,
  output logic                                     lowest_perf_o,
  output logic                                     clk_on_o,
  output logic                                     fine_step_o,
  output logic                                     therm_irq_o,
  output logic                                     overtemp_shutdown_n_o
);
  typedef struct packed {
    logic        hot_s1, hot_s2, ext_hot, drive, lowest;
    logic        act, act_log, hot_log, crit, crit_log;
    logic        t1, t1_log, t2, t2_log, trip, irq, rvalid;
    logic [2:0]  level;
    logic [23:0] step_cnt, crit_cnt;
    logic [5:0]  ofs;
    logic [6:0]  tau;
    logic [63:0] rdata;
  } state_t;

  state_t st_reg;
  state_t st_next;
  therm_link_if link ();

  logic [therm_pkg::SENS_N-1:0][6:0] sat_temp;
  logic [6:0] hot_min;
  logic       circ_hit;
  logic       circ_mod;
  logic       ext;
  logic       trip_now;
  logic [3:0] sw_duty;

  // Margin clamp: a reading past the limit reads as zero
  function automatic logic [6:0] sat_margin(input logic [7:0] raw);
    return raw[7] ? 7'h00 : raw[6:0];
  endfunction : sat_margin

  // Address match shared by read and write paths
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] base);
    return addr == base;
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Sensor saturation and hottest reading
  generate
    for (genvar i = 0; i < therm_pkg::SENS_N; i++) begin : g_sat
      assign sat_temp[i] = sat_margin(sensor_raw_i[i]);
    end
  endgenerate

  // Lowest margin is the hottest sensor; trip check on raw values
  always_comb begin
    hot_min  = 7'h7F;
    trip_now = 1'b0;
    for (int i = 0; i < therm_pkg::SENS_N; i++) begin
      if (sat_temp[i] < hot_min) begin
        hot_min = sat_temp[i];
      end
      if ($signed(sensor_raw_i[i]) <= therm_pkg::TRIP_LIMIT) begin
        trip_now = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Activation and modulation arbitration
  assign circ_hit = hot_min <= {1'b0, st_reg.ofs};
  assign circ_mod = st_reg.act && (st_reg.level == therm_pkg::THROT_MAX);
  assign ext     = !st_reg.hot_s2 && !st_reg.drive;
  assign sw_duty = therm_pkg::FINE_STEP ? odm_duty_i : {odm_duty_i[3:1], 1'b0};

  // Thermal duty first, then I/O request, then register request
  always_comb begin
    link.hot_min  = hot_min;
    link.mod_en   = circ_mod || odm_en_i || io_odm_en_i;
    link.mod_duty = sw_duty;
    if (circ_mod) begin
      link.mod_duty = therm_pkg::CIRC_DUTY;
    end else if (io_odm_en_i) begin
      link.mod_duty = io_odm_duty_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State update
  always_comb begin
    st_next        = st_reg;
    st_next.irq    = 1'b0;
    st_next.hot_s1 = hot_pin_i;
    st_next.hot_s2 = st_reg.hot_s1;
    st_next.act    = circ_hit;
    st_next.drive  = bidir_en_i && circ_hit && !idle_i;
    st_next.ext_hot = ext;
    st_next.lowest = ext;
    st_next.t1     = hot_min <= thr1_i;
    st_next.t2     = hot_min <= thr2_i;
    st_next.trip   = st_reg.trip || trip_now;

    // Gradual internal step-down while active, recovery otherwise
    st_next.step_cnt = st_reg.step_cnt + 24'h00_0001;
    if (st_reg.step_cnt == 24'(STEP_CYCLES - 1)) begin
      st_next.step_cnt = 24'h00_0000;
      if (st_reg.act && st_reg.level != therm_pkg::THROT_MAX) begin
        st_next.level = st_reg.level + 3'h1;
      end else if (!st_reg.act && st_reg.level != 3'h0) begin
        st_next.level = st_reg.level - 3'h1;
      end
    end

    // Sustained activation becomes critical
    st_next.crit_cnt = st_reg.act ? st_reg.crit_cnt + 24'h00_0001 : 24'h00_0000;
    if (st_reg.act && st_reg.crit_cnt == 24'(CRIT_CYCLES - 1)) begin
      st_next.crit     = 1'b1;
      st_next.crit_cnt = st_reg.crit_cnt;
    end
    if (!st_reg.act) begin
      st_next.crit = 1'b0;
    end

    // Writes: limit fields, and zero-to-clear on sticky bits
    if (msr_wr_i && hit(msr_addr_i, therm_pkg::LIMIT_ADDR)) begin
      st_next.ofs = msr_wdata_i[therm_pkg::LIM_OFS_LSB +: 6];
      st_next.tau = msr_wdata_i[therm_pkg::LIM_TAU_LSB +: 7];
    end
    if (msr_wr_i && (hit(msr_addr_i, therm_pkg::CORE_STAT_ADDR) || hit(msr_addr_i, therm_pkg::PKG_STAT_ADDR))) begin
      st_next.act_log = st_reg.act_log && msr_wdata_i[therm_pkg::ST_ACT_LOG];
      st_next.hot_log = st_reg.hot_log && msr_wdata_i[therm_pkg::ST_HOT_LOG];
      st_next.t1_log  = st_reg.t1_log && msr_wdata_i[therm_pkg::ST_T1_LOG];
      st_next.t2_log  = st_reg.t2_log && msr_wdata_i[therm_pkg::ST_T2_LOG];
    end
    if (msr_wr_i && hit(msr_addr_i, therm_pkg::PKG_STAT_ADDR)) begin
      st_next.crit_log = st_reg.crit_log && msr_wdata_i[therm_pkg::ST_CRIT_LOG];
    end

    // Event sets come last so they win over a same-cycle clear
    if (circ_hit && !st_reg.act) begin
      st_next.act_log = 1'b1;
    end
    if (ext != st_reg.ext_hot) begin
      st_next.hot_log = 1'b1;
      st_next.irq     = hot_int_en_i;
    end
    if (st_next.t1 != st_reg.t1) begin
      st_next.t1_log = 1'b1;
      st_next.irq    = st_next.irq || thr_int_en_i;
    end
    if (st_next.t2 != st_reg.t2) begin
      st_next.t2_log = 1'b1;
      st_next.irq    = st_next.irq || thr_int_en_i;
    end
    if (st_next.crit && !st_reg.crit) begin
      st_next.crit_log = 1'b1;
      st_next.irq      = st_next.irq || crit_int_en_i;
    end

    // Read data, registered
    st_next.rvalid = msr_rd_i;
    st_next.rdata  = 64'h0000_0000_0000_0000;
    if (msr_rd_i && hit(msr_addr_i, therm_pkg::LIMIT_ADDR)) begin
      st_next.rdata[therm_pkg::LIM_TAU_LSB +: 7] = st_reg.tau;
      st_next.rdata[therm_pkg::LIM_TJ_LSB +: 8]  = JLIM;
      st_next.rdata[therm_pkg::LIM_OFS_LSB +: 6] = st_reg.ofs;
    end else if (msr_rd_i && (hit(msr_addr_i, therm_pkg::CORE_STAT_ADDR) || hit(msr_addr_i, therm_pkg::PKG_STAT_ADDR))) begin
      st_next.rdata[therm_pkg::ST_ACT]     = st_reg.act;
      st_next.rdata[therm_pkg::ST_ACT_LOG] = st_reg.act_log;
      st_next.rdata[therm_pkg::ST_HOT]     = st_reg.ext_hot;
      st_next.rdata[therm_pkg::ST_HOT_LOG] = st_reg.hot_log;
      st_next.rdata[therm_pkg::ST_T1]      = st_reg.t1;
      st_next.rdata[therm_pkg::ST_T1_LOG]  = st_reg.t1_log;
      st_next.rdata[therm_pkg::ST_T2]      = st_reg.t2;
      st_next.rdata[therm_pkg::ST_T2_LOG]  = st_reg.t2_log;
      st_next.rdata[therm_pkg::ST_VALID]   = 1'b1;
      st_next.rdata[therm_pkg::ST_READ_LSB +: 7] = sat_temp[sensor_sel_i];
      if (hit(msr_addr_i, therm_pkg::PKG_STAT_ADDR)) begin
        st_next.rdata[therm_pkg::ST_CRIT]     = st_reg.crit;
        st_next.rdata[therm_pkg::ST_CRIT_LOG] = st_reg.crit_log;
        st_next.rdata[therm_pkg::ST_READ_LSB +: 7] = hot_min;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_reg        <= '0;
      st_reg.hot_s1 <= 1'b1;
      st_reg.hot_s2 <= 1'b1;
      st_reg.ofs    <= therm_pkg::OFS_RST;
      st_reg.tau    <= therm_pkg::TAU_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  hot_average #(
    .SAMPLE_CYCLES (AVG_CYCLES)
  ) u_avg (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .link    (link.avg_mp)
  );

  clock_modulator u_mod (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .link    (link.mod_mp)
  );

  // Outputs
  assign hot_pin_o             = 1'b0;
  assign hot_pin_oe_o          = st_reg.drive;
  assign msr_rdata_o           = st_reg.rdata;
  assign msr_rvalid_o          = st_reg.rvalid;
  assign env_temp_o            = link.avg_temp;
  assign circuit_active_o      = st_reg.act;
  assign throttle_level_o      = st_reg.level;
  assign lowest_perf_o         = st_reg.lowest;
  assign clk_on_o              = link.clk_on;
  assign fine_step_o           = therm_pkg::FINE_STEP;
  assign therm_irq_o           = st_reg.irq;
  assign overtemp_shutdown_n_o = !st_reg.trip;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_circ_activates: assert property (circ_hit |=> circuit_active_o) else $error("activation missed");
  a_hot_drive_on: assert property ((bidir_en_i && circ_hit && !idle_i) |=> hot_pin_oe_o)
    else $error("hot pin not driven");
  a_input_only: assert property (!bidir_en_i |=> !hot_pin_oe_o) else $error("hot pin driven in input mode");
  a_ext_response: assert property ((!hot_pin_i && !hot_pin_oe_o)[*3] ##1 1'b1 |-> lowest_perf_o)
    else $error("external hot response late");
  a_hold_lowest: assert property ((lowest_perf_o && !st_reg.hot_s2 && !st_reg.drive) |=> lowest_perf_o)
    else $error("lowest state released early");
  a_ext_no_mod: assert property ((!st_reg.act && !odm_en_i && !io_odm_en_i) |=> clk_on_o)
    else $error("modulation without request");
  a_circ_duty: assert property ((circuit_active_o && throttle_level_o == therm_pkg::THROT_MAX) |->
    (link.mod_en && link.mod_duty == therm_pkg::CIRC_DUTY)) else $error("thermal duty not applied");
  a_io_wins: assert property ((!circ_mod && io_odm_en_i) |-> link.mod_duty == io_odm_duty_i)
    else $error("io duty lost");
  a_trip_sticky: assert property ($fell(overtemp_shutdown_n_o) |=> (!overtemp_shutdown_n_o)[*4])
    else $error("trip released");
  a_trip_fires: assert property (trip_now |=> !overtemp_shutdown_n_o)
    else $error("trip output missed");
  a_read_answer: assert property (msr_rd_i |=> msr_rvalid_o)
    else $error("read answer missing");
  a_crit_latch: assert property ($rose(st_reg.crit) |-> st_reg.crit_log) else $error("critical log missed");
endmodule : thermal_event_control

// *** common/therm_pkg.sv ***
// Purpose: Shared constants for the thermal event control block
// Assumes: 40 MHz mclk_i, 64-bit register words
// Notes:   Timing figures are kept in their own unit and converted here
package therm_pkg;
  localparam int SENS_N        = 4;
  localparam int CLK_PERIOD_NS = 25;

  // Averaging window for the environmental interface
  localparam int AVG_WINDOW_MS     = 256;
  localparam int AVG_SAMPLES       = 256;
  localparam int AVG_SAMPLE_CYCLES = AVG_WINDOW_MS * 1000000 / CLK_PERIOD_NS / AVG_SAMPLES;

  // Clock modulation period and duty granularity (sixteenths)
  localparam int MOD_PERIOD_US     = 32;
  localparam int MOD_PERIOD_CYCLES = MOD_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int MOD_STEP_CYCLES   = MOD_PERIOD_CYCLES / 16;
  localparam logic [3:0] CIRC_DUTY = 4'h4;
  localparam logic       FINE_STEP = 1'h1;

  // External hot response bound and internal step-down pace
  localparam int EXT_RESP_US       = 100;
  localparam int EXT_RESP_CYCLES   = EXT_RESP_US * 1000 / CLK_PERIOD_NS;
  localparam int THROT_STEP_MS     = 1;
  localparam int THROT_STEP_CYCLES = THROT_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CRIT_DWELL_MS     = 4;
  localparam int CRIT_CYCLES       = CRIT_DWELL_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [2:0] THROT_MAX = 3'h7;

  // Trip point: ten degrees above the junction limit
  localparam logic signed [7:0] TRIP_LIMIT = 8'hF6;

  // Register addresses
  localparam logic [15:0] CORE_STAT_ADDR = 16'h019C;
  localparam logic [15:0] LIMIT_ADDR     = 16'h01A2;
  localparam logic [15:0] PKG_STAT_ADDR  = 16'h01B1;

  // Status field positions
  localparam int ST_ACT      = 0;
  localparam int ST_ACT_LOG  = 1;
  localparam int ST_HOT      = 2;
  localparam int ST_HOT_LOG  = 3;
  localparam int ST_CRIT     = 4;
  localparam int ST_CRIT_LOG = 5;
  localparam int ST_T1       = 6;
  localparam int ST_T1_LOG   = 7;
  localparam int ST_T2       = 8;
  localparam int ST_T2_LOG   = 9;
  localparam int ST_READ_LSB = 16;
  localparam int ST_VALID    = 31;

  // Limit reference field positions and reset values
  localparam int LIM_TAU_LSB = 0;
  localparam int LIM_TJ_LSB  = 16;
  localparam int LIM_OFS_LSB = 24;
  localparam logic [7:0] JLIM_DEFAULT  = 8'h64;
  localparam logic [5:0] OFS_RST       = 6'h00;
  localparam logic [6:0] TAU_RST       = 7'h00;
endpackage : therm_pkg

// *** common/therm_link_if.sv ***
// Purpose: Carrier between the thermal top and its helper modules
// Assumes: All signals on mclk_i
// Notes:   hot_min is the hottest sensor margin, lower means hotter
interface therm_link_if;
  logic [6:0] hot_min;
  logic [6:0] avg_temp;
  logic       mod_en;
  logic [3:0] mod_duty;
  logic       clk_on;

  modport top_mp (output hot_min, mod_en, mod_duty, input avg_temp, clk_on);
  modport avg_mp (input hot_min, output avg_temp);
  modport mod_mp (input mod_en, mod_duty, output clk_on);
endinterface : therm_link_if

// *** rtl/hot_average.sv ***
// Purpose: Windowed average of the hottest sensor margin
// Assumes: hot_min is already saturated
// Notes:   256 samples per window, result updates once per window
module hot_average #(
  parameter int SAMPLE_CYCLES = therm_pkg::AVG_SAMPLE_CYCLES
) (
  input  wire logic   mclk_i,
  input  wire logic   reset_i,
  therm_link_if.avg_mp link
);
  typedef struct packed {
    logic [23:0] cnt;
    logic [7:0]  idx;
    logic [14:0] acc;
    logic [6:0]  avg;
  } avg_state_t;

  avg_state_t st_reg;
  avg_state_t st_next;

  // Sample once per tick, divide the full sum by 256 at wrap
  always_comb begin
    st_next = st_reg;
    st_next.cnt = st_reg.cnt + 24'h00_0001;
    if (st_reg.cnt == 24'(SAMPLE_CYCLES - 1)) begin
      st_next.cnt = 24'h00_0000;
      st_next.idx = st_reg.idx + 8'h01;
      st_next.acc = st_reg.acc + {8'h00, link.hot_min};
      if (st_reg.idx == 8'hFF) begin
        st_next.avg = st_next.acc[14:8];
        st_next.acc = 15'h0000;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.avg_temp = st_reg.avg;
endmodule : hot_average

// *** rtl/clock_modulator.sv ***
// Purpose: Fixed-period clock gate with a duty in sixteenths
// Assumes: Duty zero while enabled keeps the clock stopped
// Notes:   Period is a fixed count of core clock cycles, 32 us at 40 MHz
module clock_modulator (
  input  wire logic   mclk_i,
  input  wire logic   reset_i,
  therm_link_if.mod_mp link
);
  typedef struct packed {
    logic [10:0] phase;
    logic        on;
  } mod_state_t;

  mod_state_t st_reg;
  mod_state_t st_next;
  logic [10:0] on_len;

  // On-time length of the current duty
  assign on_len = 11'(link.mod_duty * therm_pkg::MOD_STEP_CYCLES);

  // Free phase counter and registered gate
  always_comb begin
    st_next = st_reg;
    st_next.phase = st_reg.phase + 11'h001;
    if (st_reg.phase == 11'(therm_pkg::MOD_PERIOD_CYCLES - 1)) begin
      st_next.phase = 11'h000;
    end
    st_next.on = !link.mod_en || (st_reg.phase < on_len);
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_reg <= {11'h000, 1'h1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.clk_on = st_reg.on;
endmodule : clock_modulator

// *** tb/hot_agent.sv ***
// Purpose: Platform agent that pulls the shared hot indicator pin low
// Assumes: Open-drain pin with a pull-up, requests change at the falling edge
// Notes:   Resolves the wire from both drivers and feeds it back to the device
module hot_agent (
  input  wire logic mclk_i,
  input  wire logic pull_req_i,
  input  wire logic dev_oe_i,
  input  wire logic dev_out_i,
  output logic      pin_level_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic drive_reg = 1'b0;

  // Agent holds the pin while its condition lasts and lets go when it clears
  always @(posedge mclk_i) begin
    drive_reg <= pull_req_i;
  end

  // Any low driver wins, otherwise the pull-up sets the released level
  assign pin_level_o = ((dev_oe_i && !dev_out_i) || drive_reg) ? 1'b0 : 1'b1;
endmodule : hot_agent

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the thermal event control block
// Assumes: Shortened step, dwell and averaging counts
// Notes:   Stimulus changes at the falling edge of mclk_i
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                                    mclk_i = 1'b0;
  logic                                    reset_i = 1'b1;
  logic [therm_pkg::SENS_N-1:0][7:0]       sens = {8'h32, 8'h0a, 8'h28, 8'h1e};
  logic [1:0]                              sel = 2'h1;
  logic                                    thr_ie = 1'b0, hot_ie = 1'b0, crit_ie = 1'b0;
  logic                                    bidir = 1'b0, idle = 1'b0, pull = 1'b0;
  logic                                    odm_en = 1'b0, io_en = 1'b0;
  logic [3:0]                              odm_duty = 4'h2, io_duty = 4'h8;
  logic                                    rd = 1'b0, wr = 1'b0;
  logic [15:0]                             addr = 16'h0000;
  logic [63:0]                             wdata = 64'h0, rdata, got;
  logic                                    rvalid, pin_lvl, pin_o, pin_oe, circ, lowp, clk_on, fine, irq, trip_n;
  logic [6:0]                              env;
  logic [2:0]                              lvl;
  int                                      err_total = 0, samples_checked = 0, cycles = 0, irq_cnt = 0, n, base;

  thermal_event_control #(.STEP_CYCLES(8), .CRIT_CYCLES(20), .AVG_CYCLES(2)) thermal_event_control_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .sensor_raw_i(sens), .sensor_sel_i(sel), .thr1_i(7'h14),
    .thr2_i(7'h05), .thr_int_en_i(thr_ie), .hot_int_en_i(hot_ie), .crit_int_en_i(crit_ie),
    .bidir_en_i(bidir), .idle_i(idle), .odm_en_i(odm_en), .odm_duty_i(odm_duty), .io_odm_en_i(io_en),
    .io_odm_duty_i(io_duty), .hot_pin_i(pin_lvl), .hot_pin_o(pin_o), .hot_pin_oe_o(pin_oe),
    .msr_rd_i(rd), .msr_wr_i(wr), .msr_addr_i(addr), .msr_wdata_i(wdata), .msr_rdata_o(rdata),
    .msr_rvalid_o(rvalid), .env_temp_o(env), .circuit_active_o(circ), .throttle_level_o(lvl),
    .lowest_perf_o(lowp), .clk_on_o(clk_on), .fine_step_o(fine), .therm_irq_o(irq),
    .overtemp_shutdown_n_o(trip_n));

  hot_agent hot_agent_i (.mclk_i(mclk_i), .pull_req_i(pull), .dev_oe_i(pin_oe), .dev_out_i(pin_o),
    .pin_level_o(pin_lvl));

  // Clock at 40 MHz
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Cycle ceiling and interrupt pulse counter
  always @(posedge mclk_i) begin
    cycles++;
    if (irq === 1'b1) irq_cnt++;
    if (cycles == 14000) begin
      err_total++;
      summarize();
    end
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_i);
  endtask : cyc

  // Register read: strobe for one edge, answer one edge later
  task automatic rd_reg(input logic [15:0] a, output logic [63:0] d);
    rd = 1'b1;
    addr = a;
    @(negedge mclk_i);
    rd = 1'b0;
    chk(64'(rvalid), 64'h1);
    d = rdata;
    @(negedge mclk_i);
  endtask : rd_reg

  task automatic wr_reg(input logic [15:0] a, input logic [63:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk_i);
    wr = 1'b0;
    @(negedge mclk_i);
  endtask : wr_reg

  // Count running clock cycles over one modulation period
  task automatic count_on(output int k);
    k = 0;
    repeat (therm_pkg::MOD_PERIOD_CYCLES) begin
      @(negedge mclk_i);
      if (clk_on === 1'b1) k++;
    end
  endtask : count_on

  task automatic summarize();
    $display("checked=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    cyc(5);
    reset_i = 1'b0;
    cyc(8);
    chk(64'(pin_oe), 64'h0);
    chk(64'(trip_n), 64'h1);
    chk(64'(fine), 64'h1);
    chk(64'(pin_o), 64'h0);
    chk(64'(lvl), 64'h0);
    // Per-sensor and package readings, thresholds, limit reference
    rd_reg(therm_pkg::CORE_STAT_ADDR, got);
    chk(64'(got[22:16]), 64'h28);
    rd_reg(therm_pkg::PKG_STAT_ADDR, got);
    chk(64'(got[22:16]), 64'h0a);
    chk(64'({got[8], got[6]}), 64'h1);
    rd_reg(therm_pkg::LIMIT_ADDR, got);
    chk(64'(got[29:16]), 64'h0064);
    wr_reg(therm_pkg::LIMIT_ADDR, 64'h0000_0000_0300_0000);
    rd_reg(therm_pkg::LIMIT_ADDR, got);
    chk(64'(got[29:24]), 64'h3);
    rd_reg(16'h0100, got);
    chk(got, 64'h0);
    // Hot sensor above the limit: saturated reading, activation, own drive
    bidir = 1'b1;
    sens[1] = 8'hfb;
    cyc(4);
    chk(64'({circ, pin_oe}), 64'h3);
    rd_reg(therm_pkg::CORE_STAT_ADDR, got);
    chk(64'(got[22:16]), 64'h0);
    idle = 1'b1;
    cyc(3);
    chk(64'(pin_oe), 64'h0);
    idle = 1'b0;
    cyc(3);
    chk(64'(pin_oe), 64'h1);
    pull = 1'b1;
    cyc(8);
    chk(64'(lowp), 64'h0);
    sens[1] = 8'h28;
    cyc(8);
    chk(64'({circ, lowp}), 64'h1);
    pull = 1'b0;
    wr_reg(therm_pkg::LIMIT_ADDR, 64'h0);
    cyc(8);
    // External assertion on an input-only pin, interrupt on both edges
    bidir = 1'b0;
    hot_ie = 1'b1;
    base = irq_cnt;
    pull = 1'b1;
    cyc(5);
    chk(64'(lowp), 64'h1);
    cyc(30);
    chk(64'({lowp, clk_on}), 64'h3);
    pull = 1'b0;
    cyc(6);
    chk(64'(lowp), 64'h0);
    chk(64'(irq_cnt - base), 64'h2);
    hot_ie = 1'b0;
    // Averaging keeps running while idle
    idle = 1'b1;
    cyc(1100);
    chk(64'(env), 64'h0a);
    idle = 1'b0;
    // Conflicting on-demand requests, then thermal duty override
    odm_en = 1'b1;
    io_en = 1'b1;
    cyc(1300);
    count_on(n);
    chk(64'(n), 64'(io_duty * therm_pkg::MOD_STEP_CYCLES));
    thr_ie = 1'b1;
    crit_ie = 1'b1;
    base = irq_cnt;
    sens[0] = 8'h00;
    cyc(1400);
    chk(64'(irq_cnt - base), 64'h2);
    chk(64'(lvl), 64'(therm_pkg::THROT_MAX));
    count_on(n);
    chk(64'(n), 64'(therm_pkg::MOD_PERIOD_CYCLES / 4));
    rd_reg(therm_pkg::PKG_STAT_ADDR, got);
    chk(64'(got[5:4]), 64'h3);
    // Damaging temperature trips the shutdown output
    sens[2] = 8'hf6;
    cyc(3);
    chk(64'(trip_n), 64'h0);
    summarize();
  end
endmodule : testbench
